// ==== verilog/scp_pkg.sv ====
// Constants shared by the serial configuration port design files
package scp_pkg;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int WORD_BITS = ADDR_BITS + DATA_BITS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = CNT_W'(ADDR_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_WORD_LAST = CNT_W'(WORD_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_FIRST_OUT = CNT_W'(ADDR_BITS + 1);
  // Register addresses and register default value
  localparam logic [7:0] REG_SOFT_RESET = 8'h00;
  localparam logic [7:0] REG_READBACK_CTRL = 8'h01;
  localparam logic [7:0] REG_PLL_OVERRIDE = 8'hd1;
  localparam logic [15:0] REG_DEFAULT = 16'h0000;
  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int READBACK_BIT = 0;
  localparam int HIGH_ADDR_BIT = 4;
  localparam int PLL_FORCE_BIT = 6;
  localparam int PLL_ST2_BIT = 7;
  localparam int PLL_ST3_BIT = 8;
  localparam int PLL_ST4_BIT = 9;
  // Forced PLL state codes (state number minus one)
  localparam logic [1:0] PLL_STATE1 = 2'h0;
  localparam logic [1:0] PLL_STATE2 = 2'h1;
  localparam logic [1:0] PLL_STATE3 = 2'h2;
  localparam logic [1:0] PLL_STATE4 = 2'h3;
  // Synchroniser depth plus one edge-detect stage
  localparam int SYNC_W = 3;
endpackage

// ==== verilog/scp_regs_if.sv ====
// Carrier between the serial engine and its register store
`timescale 1ns/10ps
interface scp_regs_if #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
);
  logic ce;
  logic clr;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  modport engine (
    output ce, clr, wr_en, wr_addr, wr_data, rd_addr,
    input rd_data
  );
  modport store (
    input ce, clr, wr_en, wr_addr, wr_data, rd_addr,
    output rd_data
  );
endinterface

// ==== verilog/scp_reg_store.sv ====
// Register store of the configuration port, one word per address
`timescale 1ns/10ps
module scp_reg_store #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter int DEPTH = 256
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Engine side
  scp_regs_if.store regs
);
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [DATA_W-1:0] rd_data_r;

  // ********************************
  // Storage, cleared back to defaults
  // ********************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        mem_r[i] <= scp_pkg::REG_DEFAULT;
      end else if (regs.ce) begin
        // Clear outranks a write landing in the same cycle
        if (regs.clr) begin
          mem_r[i] <= scp_pkg::REG_DEFAULT;
        end else if (regs.wr_en && regs.wr_addr == ADDR_W'(i)) begin
          mem_r[i] <= regs.wr_data;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_r <= scp_pkg::REG_DEFAULT;
    end else if (regs.ce) begin
      rd_data_r <= mem_r[regs.rd_addr];
    end
  end

  assign regs.rd_data = rd_data_r;
endmodule

// ==== verilog/scp_serial_port.sv ====
// Three-wire serial configuration port with register readback
`timescale 1ns/10ps
// Summary of operation
// - Data shifts in on serial clock rising edges only while select is low.
// - Every 24th rising edge in one select-low period writes the word.
// - Leftover bits short of 24 when select rises are dropped.
// - Back-to-back 24-bit words in one select period each write.
// - First eight bits are address, next sixteen bits are data.
// - High level on hardware reset restores all registers to defaults.
// - Writing soft reset bit restores defaults; bit then reads zero.
// - Readback output stays undriven after reset until readback enabled.
// - In readback mode only address 1 accepts writes.
// - Address 1 contents are never returned on the readback line.
// - In readback, addressed register's 16 bits leave MSB first.
// - Clearing readback bit reopens writes and releases the output.
// - Writing PLL override register with bit 6 set forces the fixed PLL state.
module scp_serial_port #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter int DEPTH = 256
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Serial pins from the controller
  input wire logic serial_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_in_line_in,
  input wire logic hw_reset_in,
  // Readback pin, two signals
  output logic serial_readback_line_out,
  output logic serial_readback_oe_out,
  // Decoded configuration
  output logic readback_mode_out,
  output logic high_addr_access_out,
  output logic pll_force_out,
  output logic [1:0] pll_state_out
);
  localparam int CW = scp_pkg::CNT_W;
  localparam int SW = scp_pkg::SYNC_W;

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [SW-1:0] sclk_r;
  logic [1:0] sel_n_r;
  logic [1:0] sdi_r;
  logic [1:0] hwr_r;
  logic sclk_rise;
  logic sclk_fall;
  logic active;
  logic [CW-1:0] bit_cnt_r;
  logic [scp_pkg::WORD_BITS-2:0] shift_r;
  logic [scp_pkg::WORD_BITS-1:0] word;
  logic [ADDR_W-1:0] word_addr;
  logic [DATA_W-1:0] word_data;
  logic commit;
  logic wr_ok;
  logic soft_rst_r;
  logic clear;
  logic readback_r;
  logic high_addr_r;
  logic pll_force_r;
  logic [1:0] pll_state_r;
  logic [1:0] pll_state_nxt;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [1:0] load_pipe_r;
  logic [DATA_W-1:0] out_sh_r;

  scp_regs_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) regs ();

  scp_reg_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .DEPTH(DEPTH)) u_store (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .regs(regs.store)
  );

  // ********************************
  // Reset release and pin synchronisers
  // ********************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= '0;
      sel_n_r <= 2'h3;
      sdi_r <= 2'h0;
      hwr_r <= 2'h0;
    end else if (clk_en_in) begin
      sclk_r <= {sclk_r[SW-2:0], serial_clk_in};
      sel_n_r <= {sel_n_r[0], serial_select_n_in};
      sdi_r <= {sdi_r[0], serial_in_line_in};
      hwr_r <= {hwr_r[0], hw_reset_in};
    end
  end

  // Edges judged on stages past the first flop only
  assign sclk_rise = sclk_r[1] & ~sclk_r[2];
  assign sclk_fall = ~sclk_r[1] & sclk_r[2];
  assign active = ~sel_n_r[1];

  // ********************************
  // Serial word assembly
  // ********************************
  // address then data, MSB first
  assign word = {shift_r, sdi_r[1]};
  assign word_addr = word[scp_pkg::WORD_BITS-1 -: ADDR_W];
  assign word_data = word[DATA_W-1:0];

  // shift only on rising edges with select low
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (clk_en_in && active && sclk_rise) begin
      shift_r <= word[scp_pkg::WORD_BITS-2:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= '0;
    end else if (clk_en_in) begin
      if (!active) begin
        bit_cnt_r <= '0;
      end else if (sclk_rise) begin
        if (bit_cnt_r == scp_pkg::CNT_WORD_LAST) begin
          bit_cnt_r <= '0;
        end else begin
          bit_cnt_r <= bit_cnt_r + CW'(1);
        end
      end
    end
  end

  // commit on the 24th rising edge
  assign commit = active && sclk_rise &&
                  bit_cnt_r == scp_pkg::CNT_WORD_LAST;
  assign wr_ok = !readback_r || word_addr == scp_pkg::REG_READBACK_CTRL;

  assign regs.ce = clk_en_in;
  assign regs.wr_en = commit && wr_ok;
  assign regs.wr_addr = word_addr;
  assign regs.wr_data = word_data;
  assign regs.rd_addr = rd_addr_r;
  assign regs.clr = clear;

  // ********************************
  // Hardware and software reset
  // ********************************
  // one-cycle clear after the reset bit lands
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
    end else if (clk_en_in) begin
      soft_rst_r <= regs.wr_en &&
                    word_addr == scp_pkg::REG_SOFT_RESET &&
                    word_data[scp_pkg::SOFT_RESET_BIT];
    end
  end
  // held for as long as the pin stays high
  assign clear = soft_rst_r | hwr_r[1];

  // ********************************
  // Decoded control shadows
  // ********************************
  // override value to fixed state
  always_comb begin
    if (word_data[scp_pkg::PLL_ST4_BIT]) begin
      pll_state_nxt = scp_pkg::PLL_STATE4;
    end else if (word_data[scp_pkg::PLL_ST3_BIT]) begin
      pll_state_nxt = scp_pkg::PLL_STATE3;
    end else if (word_data[scp_pkg::PLL_ST2_BIT]) begin
      pll_state_nxt = scp_pkg::PLL_STATE2;
    end else begin
      pll_state_nxt = scp_pkg::PLL_STATE1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      readback_r <= 1'b0;
      high_addr_r <= 1'b0;
    end else if (clk_en_in) begin
      if (clear) begin
        readback_r <= 1'b0;
        high_addr_r <= 1'b0;
      end else if (regs.wr_en &&
                   word_addr == scp_pkg::REG_READBACK_CTRL) begin
        readback_r <= word_data[scp_pkg::READBACK_BIT];
        high_addr_r <= word_data[scp_pkg::HIGH_ADDR_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pll_force_r <= 1'b0;
      pll_state_r <= scp_pkg::PLL_STATE1;
    end else if (clk_en_in) begin
      if (clear) begin
        pll_force_r <= 1'b0;
        pll_state_r <= scp_pkg::PLL_STATE1;
      end else if (regs.wr_en &&
                   word_addr == scp_pkg::REG_PLL_OVERRIDE) begin
        pll_force_r <= word_data[scp_pkg::PLL_FORCE_BIT];
        pll_state_r <= pll_state_nxt;
      end
    end
  end

  // ********************************
  // Readback shifter
  // ********************************
  // Address known after eighth rising edge; store answers two cycles on
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= '0;
      load_pipe_r <= 2'h0;
    end else if (clk_en_in) begin
      load_pipe_r <= {load_pipe_r[0], 1'b0};
      if (active && sclk_rise && bit_cnt_r == scp_pkg::CNT_ADDR_LAST) begin
        rd_addr_r <= word[ADDR_W-1:0];
        load_pipe_r <= {load_pipe_r[0], 1'b1};
      end
    end
  end

  // Load must beat the next falling edge; fine well below 15 MHz
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_r <= '0;
    end else if (clk_en_in) begin
      if (load_pipe_r[1]) begin
        if (rd_addr_r == scp_pkg::REG_READBACK_CTRL) begin
          out_sh_r <= '0;
        end else begin
          out_sh_r <= regs.rd_data;
        end
      // advance on falling edges after the ninth rise
      end else if (active && sclk_fall &&
                   bit_cnt_r >= scp_pkg::CNT_FIRST_OUT) begin
        out_sh_r <= {out_sh_r[DATA_W-2:0], 1'b0};
      end
    end
  end

  // MSB first on the readback line
  assign serial_readback_line_out = out_sh_r[DATA_W-1];
  assign serial_readback_oe_out = readback_r;
  assign readback_mode_out = readback_r;
  assign high_addr_access_out = high_addr_r;
  assign pll_force_out = pll_force_r;
  assign pll_state_out = pll_state_r;
endmodule

// ==== tb/scp_host_model.sv ====
// Host controller model driving the three-wire configuration port
`timescale 1ns/10ps
module scp_host_model (
  // Clock and readback pin
  input wire logic clk_in,
  input wire logic rdbk_in,
  // Serial pins
  output logic sel_n_out,
  output logic sclk_out,
  output logic data_line_out
);
  // ****************************************
  // Serial framing tasks
  // ****************************************
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    data_line_out = 1'b0;
  end
  // 200 ns period, capture at rise
  task automatic bit_out(input logic b, output logic r);
    sclk_out <= 1'b0;
    data_line_out <= b;
    repeat (4) @(posedge clk_in);
    sclk_out <= 1'b1;
    r = rdbk_in;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic open();
    @(posedge clk_in);
    sel_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // Released data line shows the inverse, not a stale level
  task automatic close();
    sclk_out <= 1'b0;
    data_line_out <= ~data_line_out;
    repeat (4) @(posedge clk_in);
    sel_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic word(input logic [23:0] w, output logic [15:0] rd);
    logic r;
    for (int i = 23; i >= 0; i--) begin
      bit_out(w[i], r);
      if (i < 16) rd[i] = r;
    end
  endtask
  task automatic bits6(input logic [5:0] b);
    logic r;
    for (int i = 5; i >= 0; i--) bit_out(b[i], r);
  endtask
endmodule

// ==== tb/scp_chk.sv ====
// Assertion checker for the serial configuration port
`timescale 1ns/10ps
module scp_chk (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Serial pins
  input wire logic serial_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_in_line_in,
  input wire logic hw_reset_in,
  // Outputs
  input wire logic serial_readback_line_out,
  input wire logic serial_readback_oe_out,
  input wire logic readback_mode_out,
  input wire logic high_addr_access_out,
  input wire logic pll_force_out,
  input wire logic [1:0] pll_state_out
);
  // ****************************************
  // Port properties
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Longer than sync plus commit latency
  sequence idle_s;
    (serial_select_n_in && !hw_reset_in)[*8];
  endsequence
  chk_idle_line_hold: assert property (
    idle_s |=> $stable(serial_readback_line_out))
    else $error("readback line moved while idle");
  chk_reset_quiet: assert property (
    $rose(rst_n_in) |-> !serial_readback_oe_out ##1 !serial_readback_oe_out)
    else $error("readback driven after reset");
  chk_hw_clears: assert property (
    hw_reset_in[*5] |-> !(readback_mode_out || high_addr_access_out ||
    pll_force_out) && pll_state_out == 2'h0)
    else $error("hardware reset left config set");
  chk_idle_pll_hold: assert property (
    idle_s |=> $stable(pll_state_out) && $stable(pll_force_out))
    else $error("pll config changed while idle");
  chk_idle_mode_hold: assert property (
    idle_s |=> $stable(readback_mode_out))
    else $error("mode changed while idle");
  chk_idle_access_hold: assert property (
    idle_s |=> $stable(high_addr_access_out))
    else $error("access bit changed while idle");
  chk_lock_pll: assert property (
    readback_mode_out && $past(readback_mode_out) |->
    $stable(pll_state_out) && $stable(pll_force_out))
    else $error("pll written in readback mode");
  chk_force_gate: assert property (
    $rose(pll_force_out) |-> !$past(readback_mode_out))
    else $error("force bit set in readback mode");
endmodule
bind scp_serial_port scp_chk chk_i (.*);

// ==== tb/test_serial_config_port_readback.sv ====
// Self-checking bench for the serial configuration port
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_serial_config_port_readback;
  logic clk_in, rst_n_in, hw_reset_in, clk_en, sel_n, sclk, sdi;
  logic rb_line, rb_oe, mode, access, pll_force;
  logic [1:0] pll_st;
  logic [15:0] got;
  int miscompares, checks_done;
  // forced state codes 1 to 4
  logic [15:0] codes [4] = '{16'h0040, 16'h00c0, 16'h0140, 16'h0240};
  wire rb_pin = rb_oe ? rb_line : 1'bz;
  // ****************************************
  // Structure and tasks
  // ****************************************
  scp_serial_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .clk_en_in(clk_en), .serial_select_n_in(sel_n), .serial_clk_in(sclk),
    .serial_in_line_in(sdi), .hw_reset_in(hw_reset_in),
    .serial_readback_line_out(rb_line), .serial_readback_oe_out(rb_oe),
    .readback_mode_out(mode), .high_addr_access_out(access),
    .pll_force_out(pll_force), .pll_state_out(pll_st));
  scp_host_model host (.clk_in(clk_in), .rdbk_in(rb_pin), .sel_n_out(sel_n),
    .sclk_out(sclk), .data_line_out(sdi));
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] r);
    host.open();
    host.word({a, d}, r);
    host.close();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    hw_reset_in = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    `CHK("oe after reset", 1'b0, rb_oe)
    `CHK("pll after reset", 3'h0, {pll_force, pll_st})
    xfer(8'h01, 16'h0010, got);
    `CHK("test access", 1'b1, access)
    for (int i = 0; i < 4; i++) begin
      xfer(8'hd1, codes[i], got);
      `CHK("forced state", {1'b1, 2'(i)}, {pll_force, pll_st})
    end
    host.open();
    host.word({8'hd1, 16'h0040}, got);
    host.word({8'hd1, 16'h0140}, got);
    host.bits6(6'h2d);
    host.close();
    `CHK("two words", 2'h2, pll_st)
    host.bits6(6'h3f);
    xfer(8'hd1, 16'h00c0, got);
    `CHK("after partial", 2'h1, pll_st)
    xfer(8'h01, 16'h0011, got);
    `CHK("mode on", 2'h3, {rb_oe, mode})
    xfer(8'hd1, 16'h0240, got);
    `CHK("read pll", 16'h00c0, got)
    `CHK("write blocked", 2'h1, pll_st)
    xfer(8'h01, 16'h0011, got);
    `CHK("reg1 hidden", 16'h0000, got)
    xfer(8'h01, 16'h0010, got);
    `CHK("mode off", 2'h0, {rb_oe, mode})
    xfer(8'hd1, 16'h0240, got);
    `CHK("write reopened", 2'h3, pll_st)
    // Frozen port must let a whole word pass unseen
    clk_en <= 1'b0;
    xfer(8'hd1, 16'h0040, got);
    clk_en <= 1'b1;
    `CHK("frozen", 2'h3, pll_st)
    xfer(8'h00, 16'h0001, got);
    `CHK("soft reset", 4'h0, {access, pll_force, pll_st})
    xfer(8'hd1, 16'h0140, got);
    xfer(8'h01, 16'h0011, got);
    xfer(8'h00, 16'h0000, got);
    `CHK("reset bit clear", 16'h0000, got)
    hw_reset_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    hw_reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK("hw reset", 6'h0, {rb_oe, mode, access, pll_force, pll_st})
    report_and_stop();
  end
endmodule
